/* verilog/memory_space_defines.svh */
// constants for the memory space address decoder
`ifndef MEMORY_SPACE_DEFINES_SVH
`define MEMORY_SPACE_DEFINES_SVH
`define PROG_USER_TOP 24'h7fffff
`define PROG_RESET_ADDR 24'h000000
`define PROG_RESET_TARGET 24'h000002
`define PROG_VEC_END 24'h000200
`define PROG_IVT1_LO 24'h000004
`define PROG_IVT1_HI 24'h0000ff
`define PROG_IVT2_LO 24'h000100
`define PROG_IVT2_HI 24'h0001ff
`define PROG_CFG_ADDR 24'h00abf8
`define PROG_CFG_WORDS 3'h4
`define PROG_STEP 23'h000002
`define TBL_PAGE_CFG_BIT 7
`define PSV_ENABLE_BIT 2
`define DATA_IMPL_TOP 16'h3fff
`define DATA_SFR_TOP 16'h07ff
`define DATA_NEAR_TOP 16'h1fff
`endif

/* verilog/memory_space_pkg.sv */
// types for the memory space address decoder
package memory_space_pkg;
  typedef enum logic [1:0] {PC_HOLD, PC_INC, PC_DEC, PC_LOAD} pc_op_e;
  typedef enum logic [1:0] {EXT_NONE, EXT_SIGN, EXT_ZERO} ext_op_e;
  typedef enum logic [1:0] {DREG_SFR, DREG_RAM, DREG_PSV, DREG_NONE} data_region_e;
  // one data-space access request from the core
  typedef struct packed {
    logic valid;
    logic is_byte;
    logic [15:0] addr;
  } data_req_s;
  typedef struct packed {
    logic [15:0] wdata;
    logic post_inc;
  } write_info_s;
endpackage

/* verilog/memory_space_address_decoder.sv */
// program and data space address decode, byte lanes and misalignment trapping
`timescale 1ns/1ps
`default_nettype none
`include "memory_space_defines.svh"

// Contract
// - program addresses are 24 bits, from 23-bit counter or table/remap source
// - user access limited to 000000h-7FFFFFh; table ops reach config when page bit 7
// - program location is lower word even address, upper word odd, top byte unused
// - program addresses lower-word aligned; counter steps by two up or down
// - fetch starts at 000000h after reset; user puts jump there, target at 000002h
// - addresses 00000h to 0001FFh reserved for execution vectors
// - two vector tables, 000004h-0000FFh and 000100h-0001FFh
// - top four program words hold configuration, copied to registers on every reset
// - 16-bit byte effective addresses, 64 Kbytes data space
// - data addresses with top bit clear are memory; set goes to program window
// - 16 Kbytes implemented; reads outside return zero
// - separate read and write address generation units
// - low byte at even address, high byte at odd address
// - post-increment steps 1 for bytes, 2 for words
// - byte read takes whole word, selects lane by address bit 0, low lane
// - shared word decode, separate lane write strobes
// - word access at odd address raises address error trap, never split
// - misaligned read completes, misaligned write suppressed, then trap
// - byte loads go into low byte of register, high byte kept
// - sign-extend 8 to 16 bits and zero-extend clearing high byte
// - 0000h-1FFFh reachable by 13-bit field; 16-bit move field reaches all
// - special registers within 0000h-07FFh; unimplemented ones read zero
// - program window only active while window enable bit of core control set
module memory_space_address_decoder #(
  parameter logic [23:0] CFG_BASE = `PROG_CFG_ADDR
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // program counter control
  input wire memory_space_pkg::pc_op_e pc_op_i,
  input wire logic [22:0] pc_load_i,
  input wire logic tbl_access_i,
  input wire logic [7:0] table_page_register_i,
  input wire logic [15:0] tbl_offset_i,
  input wire logic [15:0] core_control_register_i,
  input wire logic [7:0] psv_page_i,
  // program memory side
  output logic [23:0] prog_addr_o,
  output logic prog_addr_legal_o,
  output logic prog_in_vector_o,
  output logic prog_in_ivt_o,
  output logic [22:0] program_counter_o,
  // configuration copy at reset
  input wire logic [23:0] prog_rdata_i,
  output logic [3:0][23:0] cfg_word_o,
  output logic cfg_done_o,
  // data read unit
  input wire memory_space_pkg::data_req_s rd_req_i,
  input wire logic rd_direct13_i,
  input wire logic rd_post_inc_i,
  input wire logic [15:0] mem_rdata_i,
  input wire logic sfr_hit_i,
  output logic [15:0] rd_addr_o,
  output logic [15:0] rd_ptr_o,
  output logic [15:0] rd_data_o,
  output logic rd_psv_o,
  // data write unit
  input wire memory_space_pkg::data_req_s wr_req_i,
  input wire memory_space_pkg::write_info_s wr_info_i,
  output logic [15:0] wr_addr_o,
  output logic [15:0] wr_ptr_o,
  output logic [1:0] wr_lane_o,
  output logic [15:0] wr_data_o,
  // working register byte load and extension
  input wire logic [15:0] wreg_old_i,
  input wire memory_space_pkg::ext_op_e ext_op_i,
  output logic [15:0] wreg_new_o,
  // trap
  output logic addr_error_trap_o
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic memory_space_pkg::data_region_e region_of(input logic [15:0] a, input logic psv_en);
    if (a[15])
      region_of = psv_en ? memory_space_pkg::DREG_PSV : memory_space_pkg::DREG_NONE;
    else if (a <= `DATA_SFR_TOP)
      region_of = memory_space_pkg::DREG_SFR;
    else if (a <= `DATA_IMPL_TOP)
      region_of = memory_space_pkg::DREG_RAM;
    else
      region_of = memory_space_pkg::DREG_NONE;
  endfunction

  function automatic logic [15:0] step_of(input logic [15:0] a, input logic is_byte);
    step_of = a + (is_byte ? 16'h0001 : 16'h0002);
  endfunction

  logic psv_en;
  assign psv_en = core_control_register_i[`PSV_ENABLE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // program counter
  logic [22:0] pc_r;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_r <= 23'h000000;
    end else begin
      unique case (pc_op_i)
        memory_space_pkg::PC_HOLD: pc_r <= pc_r;
        memory_space_pkg::PC_INC: pc_r <= pc_r + `PROG_STEP;
        memory_space_pkg::PC_DEC: pc_r <= pc_r - `PROG_STEP;
        default: pc_r <= {pc_load_i[22:1], 1'b0};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration copy: four words read from the top of program memory
  logic [2:0] cfg_cnt_r;
  logic [23:0] cfg_addr;
  // configuration words sit on consecutive program word addresses, two apart
  assign cfg_addr = CFG_BASE + {21'h000000, cfg_cnt_r[1:0], 1'b0};
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_cnt_r <= 3'h0;
      cfg_word_o <= '0;
      cfg_done_o <= 1'b0;
    end else if (cfg_cnt_r != `PROG_CFG_WORDS + 3'h1) begin
      // word n is on prog_rdata_i one cycle after address n
      if (cfg_cnt_r != 3'h0)
        cfg_word_o[cfg_cnt_r[1:0] - 2'h1] <= {8'h00, prog_rdata_i[15:0]};
      cfg_cnt_r <= cfg_cnt_r + 3'h1;
      cfg_done_o <= (cfg_cnt_r == `PROG_CFG_WORDS);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program address formation
  logic [23:0] prog_src;
  logic prog_legal;
  always_comb begin
    if (!cfg_done_o && cfg_cnt_r != `PROG_CFG_WORDS)
      prog_src = cfg_addr;
    else if (tbl_access_i)
      prog_src = {table_page_register_i, tbl_offset_i};
    else if (rd_req_i.valid && rd_req_i.addr[15] && psv_en)
      prog_src = {1'b0, psv_page_i, rd_req_i.addr[14:0]};
    else
      prog_src = {1'b0, pc_r};
    prog_legal = (prog_src <= `PROG_USER_TOP) ||
                 (tbl_access_i && table_page_register_i[`TBL_PAGE_CFG_BIT]);
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prog_addr_o <= `PROG_RESET_ADDR;
      prog_addr_legal_o <= 1'b1;
      prog_in_vector_o <= 1'b1;
      prog_in_ivt_o <= 1'b0;
      program_counter_o <= 23'h000000;
    end else begin
      prog_addr_o <= prog_src;
      prog_addr_legal_o <= prog_legal;
      prog_in_vector_o <= prog_src < `PROG_VEC_END;
      prog_in_ivt_o <= (prog_src >= `PROG_IVT1_LO && prog_src <= `PROG_IVT1_HI) ||
                       (prog_src >= `PROG_IVT2_LO && prog_src <= `PROG_IVT2_HI);
      program_counter_o <= pc_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read address generation unit
  logic [15:0] rd_ea;
  logic rd_misalign;
  memory_space_pkg::data_region_e rd_region;
  logic [7:0] rd_byte;
  assign rd_ea = rd_direct13_i ? {3'h0, rd_req_i.addr[12:0]} : rd_req_i.addr;
  assign rd_misalign = rd_req_i.valid && !rd_req_i.is_byte && rd_ea[0];
  assign rd_region = region_of(rd_ea, psv_en);
  assign rd_byte = rd_ea[0] ? mem_rdata_i[15:8] : mem_rdata_i[7:0];

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_addr_o <= 16'h0000;
      rd_ptr_o <= 16'h0000;
      rd_data_o <= 16'h0000;
      rd_psv_o <= 1'b0;
    end else if (rd_req_i.valid) begin
      rd_addr_o <= {rd_ea[15:1], 1'b0};
      rd_ptr_o <= rd_post_inc_i ? step_of(rd_ea, rd_req_i.is_byte) : rd_ea;
      rd_psv_o <= rd_region == memory_space_pkg::DREG_PSV;
      // misaligned read still completes; trap is raised on the same edge as the data
      if (rd_region == memory_space_pkg::DREG_NONE ||
          (rd_region == memory_space_pkg::DREG_SFR && !sfr_hit_i))
        rd_data_o <= 16'h0000;
      else
        rd_data_o <= rd_req_i.is_byte ? {8'h00, rd_byte} : mem_rdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // working register update for byte loads and extension
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wreg_new_o <= 16'h0000;
    end else begin
      unique case (ext_op_i)
        memory_space_pkg::EXT_SIGN: wreg_new_o <= {{8{wreg_old_i[7]}}, wreg_old_i[7:0]};
        memory_space_pkg::EXT_ZERO: wreg_new_o <= {8'h00, wreg_old_i[7:0]};
        default: wreg_new_o <= rd_req_i.is_byte ? {wreg_old_i[15:8], rd_byte} : mem_rdata_i;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write address generation unit
  logic wr_misalign;
  logic wr_mapped;
  memory_space_pkg::data_region_e wr_region;
  assign wr_misalign = wr_req_i.valid && !wr_req_i.is_byte && wr_req_i.addr[0];
  assign wr_region = region_of(wr_req_i.addr, 1'b0);
  assign wr_mapped = wr_region != memory_space_pkg::DREG_NONE;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_addr_o <= 16'h0000;
      wr_ptr_o <= 16'h0000;
      wr_lane_o <= 2'b00;
      wr_data_o <= 16'h0000;
    end else begin
      wr_addr_o <= {wr_req_i.addr[15:1], 1'b0};
      if (wr_req_i.valid)
        wr_ptr_o <= wr_info_i.post_inc ? step_of(wr_req_i.addr, wr_req_i.is_byte) : wr_req_i.addr;
      wr_data_o <= wr_req_i.is_byte ? {2{wr_info_i.wdata[7:0]}} : wr_info_i.wdata;
      if (!wr_req_i.valid || wr_misalign || !wr_mapped)
        wr_lane_o <= 2'b00;
      else if (wr_req_i.is_byte)
        wr_lane_o <= wr_req_i.addr[0] ? 2'b10 : 2'b01;
      else
        wr_lane_o <= 2'b11;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address error trap
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      addr_error_trap_o <= 1'b0;
    else
      addr_error_trap_o <= rd_misalign || wr_misalign;
  end

endmodule
`default_nettype wire

/* tb/core_array_model.sv */
// array side model: data words, register hit map and program words
`timescale 1ns/1ps
`default_nettype none
module core_array_model (
  // request addresses
  input wire logic [15:0] data_addr_i,
  input wire logic [23:0] prog_addr_i,
  // answers in the same cycle
  output logic [15:0] data_word_o,
  output logic reg_hit_o,
  output logic [23:0] prog_word_o
);
  // a word's content follows its word address, so both byte lanes are distinct
  assign data_word_o = {data_addr_i[15:1], 1'b0} ^ 16'h5ac3;
  // 0500h-05ffh holds no implemented register
  assign reg_hit_o = data_addr_i[11:8] != 4'h5;
  // top byte of the upper word stays empty
  assign prog_word_o = {8'h00, prog_addr_i[15:0] ^ 16'ha5c3};
endmodule
`default_nettype wire

/* tb/memory_space_checker_asserts.sv */
// address decoder port checks and their bind
`timescale 1ns/1ps
`default_nettype none
module memory_space_checker_asserts (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // watched ports
  input wire memory_space_pkg::data_req_s rd_req_i,
  input wire memory_space_pkg::data_req_s wr_req_i,
  input wire logic rd_post_inc_i,
  input wire logic [15:0] core_control_register_i,
  input wire logic [1:0] wr_lane_o,
  input wire logic [15:0] rd_ptr_o,
  input wire logic [15:0] rd_data_o,
  input wire logic addr_error_trap_o,
  input wire logic [23:0] prog_addr_o,
  input wire logic prog_addr_legal_o,
  input wire logic prog_in_vector_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic odd_req_r;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) odd_req_r <= 1'b0;
    else odd_req_r <= (rd_req_i.valid && !rd_req_i.is_byte && rd_req_i.addr[0]) ||
                      (wr_req_i.valid && !wr_req_i.is_byte && wr_req_i.addr[0]);
  end
  sequence odd_word_rd; rd_req_i.valid && !rd_req_i.is_byte && rd_req_i.addr[0]; endsequence
  sequence odd_word_wr; wr_req_i.valid && !wr_req_i.is_byte && wr_req_i.addr[0]; endsequence
  sequence byte_wr_in; wr_req_i.valid && wr_req_i.is_byte && wr_req_i.addr < 16'h4000; endsequence
  a_odd_read_trap: assert property (odd_word_rd |=> addr_error_trap_o)
    else $error("odd word read gave no trap");
  a_odd_write_drop: assert property (odd_word_wr |=> addr_error_trap_o && wr_lane_o == 2'b00)
    else $error("odd word write not dropped");
  a_trap_cause: assert property (addr_error_trap_o |-> odd_req_r)
    else $error("trap without odd word request");
  a_byte_lane_pick: assert property (byte_wr_in |=> wr_lane_o == ($past(wr_req_i.addr[0]) ? 2'b10 : 2'b01))
    else $error("wrong byte lane strobe");
  a_word_both_lanes: assert property (wr_req_i.valid && !wr_req_i.is_byte && !wr_req_i.addr[0] &&
    wr_req_i.addr < 16'h4000 |=> wr_lane_o == 2'b11)
    else $error("word write lacks both strobes");
  a_outside_write_drop: assert property (wr_req_i.valid && !wr_req_i.addr[0] && wr_req_i.addr > 16'h3fff
    |=> wr_lane_o == 2'b00 && !addr_error_trap_o)
    else $error("write outside memory not dropped silently");
  a_ptr_step_size: assert property (rd_req_i.valid && rd_post_inc_i |=>
    rd_ptr_o == $past(rd_req_i.addr) + ($past(rd_req_i.is_byte) ? 16'h0001 : 16'h0002))
    else $error("pointer step not scaled by size");
  a_window_off_zero: assert property (rd_req_i.valid && rd_req_i.addr[15] && !core_control_register_i[2]
    |=> rd_data_o == 16'h0000)
    else $error("window read with window off not zero");
  a_user_range_legal: assert property (prog_addr_o <= 24'h7fffff |-> prog_addr_legal_o)
    else $error("user program address flagged illegal");
  a_vector_region: assert property (prog_in_vector_o == (prog_addr_o < 24'h000200))
    else $error("vector region flag wrong");
endmodule
bind memory_space_address_decoder memory_space_checker_asserts i_chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
  .rd_req_i(rd_req_i), .wr_req_i(wr_req_i), .rd_post_inc_i(rd_post_inc_i), .core_control_register_i(core_control_register_i),
  .wr_lane_o(wr_lane_o), .rd_ptr_o(rd_ptr_o), .rd_data_o(rd_data_o), .addr_error_trap_o(addr_error_trap_o),
  .prog_addr_o(prog_addr_o), .prog_addr_legal_o(prog_addr_legal_o), .prog_in_vector_o(prog_in_vector_o));
`default_nettype wire

/* tb/tb_memory_space_address_decoder.sv */
// self-checking bench for the memory space address decoder
`timescale 1ns/1ps
`default_nettype none
module tb_memory_space_address_decoder;
  logic sys_clk, rstn, rd_pi, legal, in_vec, in_ivt, cfg_done, trap, sfr_hit;
  logic [22:0] pc_load;
  logic [23:0] prog_addr, prog_rdata, p0;
  logic [15:0] ccr, wreg_old, wreg_new, mem_rdata, rd_addr, rd_ptr, rd_data, wr_addr, wr_ptr, wr_data, w;
  logic [1:0] wr_lane;
  logic tbl, d13, rd_psv;
  logic [7:0] tpage;
  logic [15:0] toff;
  logic [22:0] pc_q;
  logic [3:0][23:0] cfg_word;
  memory_space_pkg::pc_op_e pc_op;
  memory_space_pkg::ext_op_e ext_op;
  memory_space_pkg::data_req_s rd_req, wr_req;
  memory_space_pkg::write_info_s wr_info;
  int errors, checks_done;
  memory_space_address_decoder i_dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .pc_op_i(pc_op), .pc_load_i(pc_load),
    .tbl_access_i(tbl), .table_page_register_i(tpage), .tbl_offset_i(toff), .core_control_register_i(ccr),
    .psv_page_i(8'h00), .prog_addr_o(prog_addr), .prog_addr_legal_o(legal), .prog_in_vector_o(in_vec),
    .prog_in_ivt_o(in_ivt), .program_counter_o(pc_q), .prog_rdata_i(prog_rdata), .cfg_word_o(cfg_word),
    .cfg_done_o(cfg_done), .rd_req_i(rd_req), .rd_direct13_i(d13), .rd_post_inc_i(rd_pi), .mem_rdata_i(mem_rdata),
    .sfr_hit_i(sfr_hit), .rd_addr_o(rd_addr), .rd_ptr_o(rd_ptr), .rd_data_o(rd_data), .rd_psv_o(rd_psv),
    .wr_req_i(wr_req), .wr_info_i(wr_info),
    .wr_addr_o(wr_addr), .wr_ptr_o(wr_ptr), .wr_lane_o(wr_lane), .wr_data_o(wr_data), .wreg_old_i(wreg_old),
    .ext_op_i(ext_op), .wreg_new_o(wreg_new), .addr_error_trap_o(trap));
  core_array_model i_mem (.data_addr_i(rd_req.addr), .prog_addr_i(prog_addr), .data_word_o(mem_rdata),
    .reg_hit_o(sfr_hit), .prog_word_o(prog_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [15:0] a, input logic b);
    @(posedge sys_clk) rd_req <= '{1'b1, b, a};
    @(posedge sys_clk) rd_req.valid <= 1'b0;
    #1 w = {a[15:1], 1'b0} ^ 16'h5ac3;
  endtask
  task automatic wr(input logic [15:0] a, input logic b);
    @(posedge sys_clk) wr_req <= '{1'b1, b, a};
    wr_info <= '{16'h00c7, 1'b1};
    @(posedge sys_clk) wr_req.valid <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_program_counter;
    for (int i = 0; i < 50 && cfg_done !== 1'b1; i++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    #1 chk(prog_addr, 24'h000000);
    for (int k = 0; k < 4; k++) chk(cfg_word[k], {8'h00, (16'habf8 + 16'(2 * k)) ^ 16'ha5c3});
    chk(in_vec, 1'b1);
    @(posedge sys_clk) pc_op <= memory_space_pkg::PC_INC;
    repeat (3) @(posedge sys_clk);
    #1 p0 = prog_addr;
    @(posedge sys_clk) pc_op <= memory_space_pkg::PC_DEC;
    #1 chk(prog_addr - p0, 24'h000002);
    repeat (3) @(posedge sys_clk);
    #1 p0 = prog_addr;
    @(posedge sys_clk) pc_op <= memory_space_pkg::PC_LOAD;
    pc_load <= 23'h000104;
    #1 chk(p0 - prog_addr, 24'h000002);
    @(posedge sys_clk) pc_op <= memory_space_pkg::PC_HOLD;
    repeat (3) @(posedge sys_clk);
    #1 chk(prog_addr, 24'h000104);
    chk({legal, in_ivt}, 2'b11);
    chk(pc_q, 23'h000104);
  endtask
  task automatic t_table;
    @(posedge sys_clk) tbl <= 1'b1;
    tpage <= 8'h80;
    toff <= 16'h0004;
    repeat (2) @(posedge sys_clk);
    #1 chk(prog_addr, 24'h800004);
    chk({legal, in_vec}, 2'b10);
    @(posedge sys_clk) tbl <= 1'b0;
  endtask
  task automatic t_direct;
    @(posedge sys_clk) d13 <= 1'b1;
    rd_pi <= 1'b0;
    rd(16'he010, 1'b0);
    chk(rd_addr, 16'h0010);
    chk(rd_ptr, 16'h0010);
    chk(rd_data, w);
    @(posedge sys_clk) d13 <= 1'b0;
    rd_pi <= 1'b1;
  endtask
  task automatic t_data_read;
    logic [15:0] ra [5] = '{16'h1001, 16'h1000, 16'h2abc, 16'h2000, 16'h2001};
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], i < 3);
      chk(rd_addr, {ra[i][15:1], 1'b0});
      chk(rd_ptr, ra[i] + ((i < 3) ? 16'h0001 : 16'h0002));
      if (i < 3) chk(rd_data, {8'h00, ra[i][0] ? w[15:8] : w[7:0]});
      if (i < 3) chk(wreg_new, {8'h5a, ra[i][0] ? w[15:8] : w[7:0]});
      if (i == 3) chk(rd_data, w);
      chk(trap, i == 4);
    end
  endtask
  task automatic t_read_zero;
    logic [15:0] za [3] = '{16'h4000, 16'h8000, 16'h0500};
    for (int i = 0; i < 3; i++) begin
      rd(za[i], 1'b0);
      chk(rd_data, 16'h0000);
    end
    @(posedge sys_clk) ccr <= 16'h0004;
    rd(16'h8002, 1'b0);
    chk(rd_data, w);
    chk(rd_psv, 1'b1);
  endtask
  task automatic t_write_lanes;
    logic [15:0] wa [6] = '{16'h1000, 16'h1001, 16'h1002, 16'h1003, 16'h4000, 16'h9000};
    logic [1:0] el [6] = '{2'b01, 2'b10, 2'b11, 2'b00, 2'b00, 2'b00};
    for (int i = 0; i < 6; i++) begin
      wr(wa[i], i < 2);
      chk(wr_lane, el[i]);
      chk(trap, i == 3);
      if (i < 3) chk(wr_data, (i < 2) ? 16'hc7c7 : 16'h00c7);
      if (i < 3) chk(wr_ptr, wa[i] + ((i < 2) ? 16'h0001 : 16'h0002));
      if (i < 3) chk(wr_addr, 16'h1000 | {wa[i][15:2], 2'b00} & 16'h0002 | wa[i] & 16'h0002);
    end
  endtask
  task automatic t_extend;
    @(posedge sys_clk) ext_op <= memory_space_pkg::EXT_SIGN;
    wreg_old <= 16'h3c80;
    @(posedge sys_clk) ext_op <= memory_space_pkg::EXT_ZERO;
    repeat (2) @(posedge sys_clk);
    #1 chk(wreg_new, 16'h0080);
    @(posedge sys_clk) ext_op <= memory_space_pkg::EXT_SIGN;
    repeat (2) @(posedge sys_clk);
    #1 chk(wreg_new, 16'hff80);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    #(25 * 4000);
    errors++;
    tally_and_finish();
  end
  initial begin
    {rstn, rd_pi, pc_load, ccr, wreg_old, rd_req, wr_req, wr_info, errors, checks_done} = '0;
    {tbl, d13, tpage, toff} = '0;
    pc_op = memory_space_pkg::PC_HOLD;
    ext_op = memory_space_pkg::EXT_NONE;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    rd_pi <= 1'b1;
    wreg_old <= 16'h5a00;
    t_program_counter();
    t_table();
    t_data_read();
    t_read_zero();
    t_direct();
    t_write_lanes();
    t_extend();
    tally_and_finish();
  end
endmodule
`default_nettype wire
